// ==== rtl/tcc3_params.svh ====
`ifndef TCC3_PARAMS_SVH
`define TCC3_PARAMS_SVH
`define TCC3_CNT_W 16
`define TCC3_NUM_CH 3
`define TCC3_CNT_RST 16'h0000
`define TCC3_CCR_RST 16'h0000
`define TCC3_CAP_SIG_A 2'h0
`define TCC3_CAP_SIG_B 2'h1
`define TCC3_CAP_GND 2'h2
`define TCC3_CAP_VCC 2'h3
`define TCC3_CLK_PIN 2'h0
`define TCC3_CLK_AUX 2'h1
`define TCC3_CLK_SUB 2'h2
`define TCC3_CLK_ALT 2'h3
`define TCC3_EDGE_RISE 2'h1
`define TCC3_EDGE_FALL 2'h2
`define TCC3_EDGE_BOTH 2'h3
`endif

// ==== rtl/tcc3_pkg.sv ====
package tcc3_pkg;
    typedef enum logic [2:0] {
        TCC3_MODE_STOP = 3'b001,
        TCC3_MODE_CONT = 3'b010,
        TCC3_MODE_UP = 3'b100
    } tcc3_mode_type;
    typedef logic [15:0] tcc3_word_type;
endpackage : tcc3_pkg

// ==== rtl/tcc3_ch_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface tcc3_ch_if;
    logic [15:0] count;
    logic tick;
    logic cap_src;
    logic cap_evt;
    logic cmp_evt;
    logic [15:0] value;
    modport timer (output count, output tick, output cap_src, input cap_evt, input cmp_evt, input value);
    modport chan (input count, input tick, input cap_src, output cap_evt, output cmp_evt, output value);
endinterface : tcc3_ch_if
`default_nettype wire

// ==== rtl/tcc3_channel.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tcc3_params.svh"
module tcc3_channel (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic cap_mode_in,
    input wire logic [1:0] cap_edge_in,
    input wire logic load_in,
    input wire logic [15:0] load_value_in,
    tcc3_ch_if.chan bus
);
    logic src_q;
    logic armed_q;
    logic [15:0] value_q;
    logic [15:0] value_d;
    wire rise = bus.cap_src & ~src_q;
    wire fall = ~bus.cap_src & src_q;
    // No edge in the first enabled cycle after reset: the held source level is not known yet
    wire edge_hit = armed_q & ((cap_edge_in[0] & rise) | (cap_edge_in[1] & fall));
    assign bus.cap_evt = clk_en_in & cap_mode_in & edge_hit; // R2
    assign bus.cmp_evt = clk_en_in & ~cap_mode_in & bus.tick & (bus.count == value_q); // R2
    assign value_d = bus.cap_evt ? bus.count : (load_in ? load_value_in : value_q);
    assign bus.value = value_q;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            src_q <= 1'b0;
            armed_q <= 1'b0;
            value_q <= `TCC3_CCR_RST;
        end else if (clk_en_in) begin
            src_q <= bus.cap_src;
            armed_q <= 1'b1;
            value_q <= value_d; // R1
        end
    end
    chk_capture_latches_count: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
        bus.cap_evt |=> value_q == $past(bus.count)) else $error("capture value wrong");
    cov_capture: cover property (@(posedge clk_sys_in) bus.cap_evt);
endmodule : tcc3_channel
`default_nettype wire

// ==== rtl/tcc3_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tcc3_params.svh"
// Operation
// [R1] Sixteen-bit counter with three channels, each holding a 16-bit value
// [R2] Capture, compare, pulse-width outputs and interval timing supported
// [R3] Counter wrap raises the overflow interrupt request
// [R4] Each channel raises its own capture or compare interrupt request
// [R5] Counter clock picks pin, auxiliary, subsystem or alternate input
// [R6] First instance: channel 0 second input is the auxiliary clock
// [R7] First instance: channel 1 second input is the comparator output
// [R8] First instance: channel 2 second input is the pin oscillator
// [R9] Every channel also offers ground and supply capture inputs
// [R10] Clock module sources auxiliary clock from crystal or low-frequency oscillator
// [R11] Clock module supplies the subsystem clock for peripherals
// [R12] Capture select: 00 input a, 01 input b, 10 ground, 11 supply
module tcc3_timer #(
    parameter int CNT_W = `TCC3_CNT_W,
    parameter bit FIRST_INST = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire tcc3_pkg::tcc3_mode_type mode_in,
    input wire logic [1:0] clk_sel_in,
    input wire logic timer_ext_clock_pin_in,
    input wire logic aux_clock_in,
    input wire logic subsystem_clock_in,
    input wire logic alternate_clock_input_in,
    input wire logic pin_oscillator_out_in,
    input wire logic comparator_out_in,
    input wire logic [2:0] capture_in_a_in,
    input wire logic [2:0] capture_in_b_in,
    input wire logic [5:0] cap_sel_in,
    input wire logic [5:0] cap_edge_in,
    input wire logic [2:0] cap_mode_in,
    input wire logic [2:0] load_in,
    input wire logic [47:0] load_value_in,
    input wire logic [2:0] irq_clear_in,
    input wire logic ovf_clear_in,
    output logic [15:0] count_out,
    output logic [47:0] channel_value_out,
    output logic [2:0] channel_pwm_out,
    output logic [2:0] channel_irq_out,
    output logic overflow_irq_out
);
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic clk_src_q;
    logic [2:0] irq_q;
    logic [2:0] pwm_q;
    logic ovf_q;
    logic [2:0] cap_evt;
    logic [2:0] cmp_evt;
    logic [2:0] in_b_int;
    logic [47:0] val_w;
    wire logic alt_src = FIRST_INST ? pin_oscillator_out_in : alternate_clock_input_in; // R5
    wire logic sel_src = (clk_sel_in == `TCC3_CLK_PIN) ? timer_ext_clock_pin_in :
                         (clk_sel_in == `TCC3_CLK_AUX) ? aux_clock_in :
                         (clk_sel_in == `TCC3_CLK_SUB) ? subsystem_clock_in : alt_src; // R5
    // Rising edge sampled in the system clock; sources must be below half of 250 MHz
    wire logic tick = clk_en_in & sel_src & ~clk_src_q;
    wire logic running = mode_in != tcc3_pkg::TCC3_MODE_STOP;
    wire logic up_wrap = (mode_in == tcc3_pkg::TCC3_MODE_UP) && (count_q >= val_w[15:0]);
    wire logic wrap = tick & running & (up_wrap | (count_q == 16'hffff)); // R3
    assign count_d = !(tick & running) ? count_q : (up_wrap ? `TCC3_CNT_RST : count_q + 16'h0001); // R1 R2
    assign in_b_int[0] = FIRST_INST ? aux_clock_in : capture_in_b_in[0]; // R6
    assign in_b_int[1] = FIRST_INST ? comparator_out_in : capture_in_b_in[1]; // R7
    assign in_b_int[2] = FIRST_INST ? pin_oscillator_out_in : capture_in_b_in[2]; // R8
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_ch
            tcc3_ch_if chb();
            wire logic [1:0] sel = cap_sel_in[2*g+1:2*g];
            assign chb.count = count_q;
            assign chb.tick = tick & running;
            assign chb.cap_src = (sel == `TCC3_CAP_SIG_A) ? capture_in_a_in[g] :
                                 (sel == `TCC3_CAP_SIG_B) ? in_b_int[g] :
                                 (sel == `TCC3_CAP_GND) ? 1'b0 : 1'b1; // R9 R12
            assign cap_evt[g] = chb.cap_evt;
            assign cmp_evt[g] = chb.cmp_evt;
            assign val_w[16*g+15:16*g] = chb.value;
            tcc3_channel u_ch (
                .clk_sys_in(clk_sys_in),
                .sys_rst_in(sys_rst_in),
                .clk_en_in(clk_en_in),
                .cap_mode_in(cap_mode_in[g]),
                .cap_edge_in(cap_edge_in[2*g+1:2*g]),
                .load_in(load_in[g]),
                .load_value_in(load_value_in[16*g+15:16*g]),
                .bus(chb)
            );
            always_ff @(posedge clk_sys_in) begin
                if (sys_rst_in) begin
                    irq_q[g] <= 1'b0;
                    pwm_q[g] <= 1'b0;
                end else if (clk_en_in) begin
                    // Set beats clear so no event is lost
                    irq_q[g] <= cap_evt[g] | cmp_evt[g] | (irq_q[g] & ~irq_clear_in[g]); // R4
                    pwm_q[g] <= cmp_evt[g] ? 1'b0 : (wrap ? 1'b1 : pwm_q[g]); // R2
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            count_q <= `TCC3_CNT_RST;
            clk_src_q <= 1'b0;
            ovf_q <= 1'b0;
            channel_value_out <= 48'h0;
        end else if (clk_en_in) begin
            count_q <= count_d;
            clk_src_q <= sel_src;
            ovf_q <= wrap | (ovf_q & ~ovf_clear_in); // R3
            channel_value_out <= val_w;
        end
    end
    assign count_out = count_q;
    assign channel_pwm_out = pwm_q;
    assign channel_irq_out = irq_q;
    assign overflow_irq_out = ovf_q;
    chk_overflow_sets_flag: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R3
        wrap |=> overflow_irq_out) else $error("overflow flag missed");
    chk_wrap_count_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R1
        wrap |=> count_q == 16'h0000) else $error("count not zero after wrap");
    chk_channel_irq_set: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R4
        (cap_evt[0] | cmp_evt[0]) |=> channel_irq_out[0]) else $error("channel irq missed");
    chk_freeze_on_enable: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R1
        !clk_en_in |=> $stable(count_q)) else $error("count moved while frozen");
    chk_ground_no_capture: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R9
        (cap_sel_in[1:0] == 2'h2) [*2] |-> !cap_evt[0]) else $error("ground input captured");
    chk_clock_select_tick: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R5
        (clk_en_in && running && clk_sel_in == 2'h2 && subsystem_clock_in && !clk_src_q && count_q < 16'h7fff
         && mode_in == tcc3_pkg::TCC3_MODE_CONT) |=> count_q == $past(count_q) + 16'h0001)
        else $error("subsystem tick not counted");
    chk_pwm_cmp_low: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
        cmp_evt[1] |=> !channel_pwm_out[1]) else $error("pwm not cleared");
    chk_inst_b_route: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R7
        FIRST_INST |-> in_b_int[1] == comparator_out_in) else $error("comparator route wrong");
    cov_overflow: cover property (@(posedge clk_sys_in) wrap);
    cov_compare: cover property (@(posedge clk_sys_in) cmp_evt[2]);
    cov_supply_sel: cover property (@(posedge clk_sys_in) cap_sel_in[3:2] == 2'h3);
    cov_capture_irq: cover property (@(posedge clk_sys_in) cap_evt[1]);

    // Flag behaviour around set and clear
    chk_overflow_sticky: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R3
        (overflow_irq_out && !ovf_clear_in) |=> overflow_irq_out)
        else $error("overflow flag dropped");

    chk_overflow_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R3
        (ovf_clear_in && clk_en_in && !wrap) |=> !overflow_irq_out)
        else $error("overflow flag not cleared");

    chk_ovf_from_cont: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R3
        (tick && running && mode_in == tcc3_pkg::TCC3_MODE_CONT && count_q == 16'hffff) |=> overflow_irq_out)
        else $error("full count did not overflow");

    chk_irq1_set: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R4
        (cap_evt[1] | cmp_evt[1]) |=> channel_irq_out[1])
        else $error("channel one irq missed");

    chk_irq2_set: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R4
        (cap_evt[2] | cmp_evt[2]) |=> channel_irq_out[2])
        else $error("channel two irq missed");

    chk_irq0_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R4
        (irq_clear_in[0] && clk_en_in && !cap_evt[0] && !cmp_evt[0]) |=> !channel_irq_out[0])
        else $error("channel zero irq not cleared");

    chk_irq2_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R4
        (irq_clear_in[2] && clk_en_in && !cap_evt[2] && !cmp_evt[2]) |=> !channel_irq_out[2])
        else $error("channel two irq not cleared");

    // Counter progress, compare events, PWM and value outputs
    chk_stop_holds: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
        (mode_in == tcc3_pkg::TCC3_MODE_STOP) |=> $stable(count_q))
        else $error("count moved while stopped");

    chk_count_no_tick: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R1
        !(tick && running) |=> $stable(count_q))
        else $error("count moved without tick");

    chk_up_wrap_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
        (tick && running && up_wrap) |=> count_q == 16'h0000)
        else $error("up mode did not restart");

    chk_compare_only_tick: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
        !(tick && running) |-> cmp_evt == 3'h0)
        else $error("compare without tick");

    chk_pwm_wrap_high: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
        (wrap && !cmp_evt[0]) |=> channel_pwm_out[0])
        else $error("pwm not set on wrap");

    chk_pwm2_cmp_low: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
        cmp_evt[2] |=> !channel_pwm_out[2])
        else $error("pwm two not cleared");

    chk_value_out_lag: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R1
        clk_en_in |=> channel_value_out == $past(val_w))
        else $error("channel value output lag wrong");

    // Input selection
    chk_sub_select: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R5
        (clk_sel_in == 2'h2) |-> sel_src == subsystem_clock_in)
        else $error("subsystem source not selected");

    chk_alt_source: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R5
        (clk_sel_in == 2'h3 && FIRST_INST) |-> sel_src == pin_oscillator_out_in)
        else $error("alternate source wrong");

    chk_cap_src_gnd: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R9
        (cap_sel_in[1:0] == 2'h2) |-> !gen_ch[0].chb.cap_src)
        else $error("ground input not low");

    chk_cap_src_vcc: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R9
        (cap_sel_in[3:2] == 2'h3) |-> gen_ch[1].chb.cap_src)
        else $error("supply input not high");
endmodule : tcc3_timer
`default_nettype wire

// ==== test/tcc3_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the clock module and pin oscillator; its divider is cleared by sys_rst_in, unlike real clocks
module tcc3_far_model (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    output logic aux_clock_out,
    output logic subsystem_clock_out,
    output logic pin_osc_out
);
    logic [4:0] div_q;
    always_ff @(posedge clk_sys_in) begin
        div_q <= sys_rst_in ? 5'h00 : div_q + 5'h01;
    end
    assign aux_clock_out = div_q[4];
    assign subsystem_clock_out = div_q[1];
    assign pin_osc_out = div_q[2];
endmodule : tcc3_far_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys_in, sys_rst_in, clk_en_in, pin, cmp, ovf_clr, ovf, aux, sub, posc;
    logic [1:0] csel;
    tcc3_pkg::tcc3_mode_type mode;
    logic [2:0] cap_a, cap_mode, load, irq_clr, irq, pwm;
    logic [5:0] cap_sel;
    logic [47:0] load_val, vals;
    logic [15:0] count, exp_cnt;
    int num_errors = 0;
    int compares = 0;
    tcc3_far_model i_far (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .aux_clock_out(aux),
        .subsystem_clock_out(sub), .pin_osc_out(posc));
    // Second inputs tied low: only the internal wiring can make those captures happen
    tcc3_timer #(.FIRST_INST(1'b1)) i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in), .mode_in(mode), .clk_sel_in(csel), .timer_ext_clock_pin_in(pin),
        .aux_clock_in(aux), .subsystem_clock_in(sub), .alternate_clock_input_in(1'b0),
        .pin_oscillator_out_in(posc), .comparator_out_in(cmp), .capture_in_a_in(cap_a),
        .capture_in_b_in(3'h0), .cap_sel_in(cap_sel), .cap_edge_in(6'h15), .cap_mode_in(cap_mode),
        .load_in(load), .load_value_in(load_val), .irq_clear_in(irq_clr), .ovf_clear_in(ovf_clr),
        .count_out(count), .channel_value_out(vals), .channel_pwm_out(pwm),
        .channel_irq_out(irq), .overflow_irq_out(ovf));
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task step(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : step
    task look;
        @(negedge clk_sys_in);
    endtask : look
    task chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task chk_bits(input string what, input logic [2:0] exp, input logic [2:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bits
    task stop_test;
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task do_reset;
        sys_rst_in <= 1'b1;
        step(8);
        sys_rst_in <= 1'b0;
        step(1);
    endtask : do_reset
    // Source held for several cycles each way, since the design samples it as data
    task pulse;
        pin <= 1'b1;
        step(3);
        pin <= 1'b0;
        step(4);
        exp_cnt = exp_cnt + 16'h0001;
    endtask : pulse
    task t_count;
        look;
        chk_word("reset_count", 16'h0000, count);
        chk_bits("reset_flags", 3'h0, irq | {2'h0, ovf});
        step(1);
        repeat (3) pulse;
        look;
        chk_word("pin_count", exp_cnt, count);
        step(1);
        clk_en_in <= 1'b0;
        pulse;
        exp_cnt = exp_cnt - 16'h0001;
        clk_en_in <= 1'b1;
        look;
        chk_word("frozen_count", exp_cnt, count);
        step(1);
        mode <= tcc3_pkg::TCC3_MODE_STOP;
        pulse;
        exp_cnt = exp_cnt - 16'h0001;
        mode <= tcc3_pkg::TCC3_MODE_CONT;
        look;
        chk_word("stopped_count", exp_cnt, count);
        step(1);
    endtask : t_count
    // Per code: a input, internal b wiring, ground never, supply forced edge
    task cap_code(input logic [1:0] code);
        pulse;
        cap_sel <= 6'h2a;
        cap_a <= 3'h0;
        cmp <= 1'b0;
        irq_clr <= 3'h7;
        step(2);
        irq_clr <= 3'h0;
        cap_sel <= {3{code}};
        step(2);
        cap_a <= 3'h7;
        cmp <= 1'b1;
        step(80);
        look;
        chk_bits("capture_irq", (code == 2'h2) ? 3'h0 : 3'h7, irq);
        for (int k = 0; k < 3; k++) begin
            if (code != 2'h2) chk_word("captured", exp_cnt, vals[16*k +: 16]);
        end
        step(1);
    endtask : cap_code
    task t_up_wrap;
        do_reset;
        exp_cnt = 16'h0000;
        cap_mode <= 3'h0;
        load_val <= {16'h0000, 16'h0001, 16'h0003};
        load <= 3'h3;
        step(1);
        load <= 3'h0;
        mode <= tcc3_pkg::TCC3_MODE_UP;
        repeat (4) pulse;
        look;
        chk_word("wrap_count", 16'h0000, count);
        chk_bits("wrap_flags", 3'h7, {ovf, irq[0], pwm[1]});
        step(1);
        irq_clr <= 3'h7;
        step(1);
        irq_clr <= 3'h0;
        repeat (2) pulse;
        look;
        chk_bits("compare_ch1", 3'h1, {pwm[1], irq[1]});
        step(1);
        ovf_clr <= 1'b1;
        step(1);
        ovf_clr <= 1'b0;
        step(2);
        look;
        chk_bits("ovf_cleared", 3'h0, {2'h0, ovf});
        step(1);
    endtask : t_up_wrap
    task t_sources;
        for (int s = 1; s < 4; s++) begin
            do_reset;
            csel <= s[1:0];
            mode <= tcc3_pkg::TCC3_MODE_CONT;
            step(200);
            look;
            chk_bits("source_moves", 3'h1, {2'h0, count != 16'h0000});
            step(1);
        end
    endtask : t_sources
    initial begin
        {sys_rst_in, pin, cmp, ovf_clr} = 4'h8;
        clk_en_in = 1'b1;
        mode = tcc3_pkg::TCC3_MODE_CONT;
        {csel, cap_a, cap_mode, load, irq_clr, cap_sel} = 20'h00000;
        load_val = 48'h0;
        exp_cnt = 16'h0000;
        step(8);
        sys_rst_in <= 1'b0;
        step(1);
        t_count;
        cap_mode <= 3'h7;
        for (int c = 0; c < 4; c++) cap_code(c[1:0]);
        t_up_wrap;
        t_sources;
        stop_test;
    end
    initial begin
        step(20000);
        num_errors++;
        stop_test;
    end
endmodule : testbench
`default_nettype wire
